// ---- common/cmbs_pkg.sv ----
/*
 * Package for the CAN message buffer state controller: state codes, register
 * map, field layout and sizes.
 * Assumes an AHB-Lite register port with 32-bit data and a single clock.
 */
package cmbs_pkg;

    localparam int NBUF = 15;

    // Buffer state field codes
    localparam logic [3:0] ST_RX_NOT_ACTIVE = 4'h0;
    localparam logic [3:0] ST_RX_READY      = 4'h2;
    localparam logic [3:0] ST_RX_FULL       = 4'h4;
    localparam logic [3:0] ST_RX_OVERRUN    = 4'h6;
    localparam logic [3:0] ST_TX_NOT_ACTIVE = 4'h8;
    localparam logic [3:0] ST_AWAIT_REMOTE_REQUEST        = 4'ha;
    localparam logic [3:0] ST_TX_ONCE       = 4'hc;
    localparam logic [3:0] ST_REMOTE_ANSWER_ONCE   = 4'he;

    // Register byte offsets
    localparam logic [7:0] ADDR_CFG    = 8'h00;
    localparam logic [7:0] ADDR_STAT   = 8'h04;
    localparam logic [7:0] ADDR_IPND   = 8'h08;
    localparam logic [7:0] ADDR_ICLR   = 8'h0c;
    localparam logic [7:0] ADDR_IEN    = 8'h10;
    localparam logic [7:0] ADDR_BUF0   = 8'h40;

    // Per-buffer register fields
    localparam int FLD_ST_LO   = 0;
    localparam int FLD_PRI_LO  = 4;
    localparam int FLD_RTR     = 8;

    // Config register fields
    localparam int CFG_LOCK    = 0;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Event inputs from the protocol engine
    typedef struct packed {
        logic       rx_valid;
        logic [3:0] rx_buf;
        logic       rx_copy_done;
        logic       rx_remote;
        logic       crc_start;
        logic       frame_start;
        logic       tx_ok;
        logic       tx_fail;
        logic       bus_idle;
    } cmbs_evt_t;

    // Per-buffer software-visible state
    typedef struct packed {
        logic       rtr;
        logic [3:0] transmit_priority_value;
        logic [3:0] st;
    } cmbs_buf_t;

endpackage

// ---- hw/cmbs_pick.sv ----
/*
 * Transmit priority picker: finds the lowest 8-bit priority value among the
 * requesting buffers; ties go to the lower buffer number.
 * Assumes the requests and codes are stable within the cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module cmbs_pick (
    input  wire logic [cmbs_pkg::NBUF-1:0]   req,
    input  wire logic [4*cmbs_pkg::NBUF-1:0] pri_code,
    output logic                             found,
    output logic [3:0]                       idx,
    output logic [7:0]                       best
);
    always_comb begin
        found = 1'b0;
        idx   = 4'h0;
        best  = 8'hff;
        for (int i = 0; i < cmbs_pkg::NBUF; i++) begin
            // Strict compare keeps the lower number on a tie
            if (req[i] && (!found || {pri_code[4*i +: 4], 4'(i)} < best)) begin
                found = 1'b1;
                idx   = 4'(i);
                best  = {pri_code[4*i +: 4], 4'(i)};
            end
        end
    end
endmodule
`default_nettype wire

// ---- hw/cmbs_rxnext.sv ----
/*
 * Receive next-state function of one buffer when a frame is copied into it.
 * Assumes the current state already includes any software write.
 */
`timescale 1ns/1ps
`default_nettype none
module cmbs_rxnext (
    input  wire logic [3:0] cur,
    output logic [3:0]      nxt
);
    always_comb begin
        // Busy bit is set while the copy runs, so decode without it
        unique case ({cur[3:1], 1'b0})
            cmbs_pkg::ST_RX_READY:   nxt = cmbs_pkg::ST_RX_FULL;
            cmbs_pkg::ST_RX_FULL:    nxt = cmbs_pkg::ST_RX_OVERRUN;
            cmbs_pkg::ST_RX_OVERRUN: nxt = cmbs_pkg::ST_RX_OVERRUN;
            default:                 nxt = cur;
        endcase
    end
endmodule
`default_nettype wire

// ---- hw/cmbs_ctrl.sv ----
/*
 * CAN message buffer state controller: per-buffer state fields, receive
 * copy/full/overrun handling, transmit scheduling, pre-emption, retry and
 * remote-frame handling, with an AHB-Lite register slave.
 * Assumes a protocol engine on the same clock that gives one-cycle event
 * pulses (frame accepted, copy done, CRC start, frame start, tx ok/fail).
 */
// Summary of operation
// - Inactive receive is 0000b, receive-ready 0010b; software write arms.
// - Accepted frame shows busy during copy, then state becomes full.
// - Frame into full buffer before re-arm moves state to overrun.
// - Full is 0100b; copy into full buffer reads 0101b.
// - Enabled receive-ready buffer raises interrupt on entering full.
// - Lock option locks buffer after first frame until re-armed.
// - Top state bit set means transmit buffer; inactive allows loading.
// - Transmit-once shows busy, returns to inactive after data frame.
// - Failed transmission stays busy and retries until success; a state write to the current buffer does not stop its retries.
// - Remote request sent once moves buffer to receive-ready.
// - Wait-for-remote on remote frame goes answer-once, sends, returns.
// - Writing answer-once sends at once, then waits for remote.
// - While transmit-busy only state bits three to one are writable.
// - From CRC start pick highest pending request and mark it busy.
// - Higher request before frame start displaces scheduled buffer to once.
// - Lost arbitration or error stops, waits idle, resends the same buffer.
// - State bit zero is the busy bit during copy or send.
// - Answer-once is 1110b, 1111b busy; wait-for-remote 1010b.
// - Write during copy: ready to full, full to overrun, inactive stays.
// - Priority is 4-bit code above 4-bit buffer number; lowest wins.
`timescale 1ns/1ps
`default_nettype none
module cmbs_ctrl (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [7:0]               haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic [31:0]                   hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input  wire cmbs_pkg::cmbs_evt_t      evt,
    output logic                          tx_request,
    output logic [3:0]                    tx_buf,
    output logic                          tx_buf_rtr,
    output logic                          receive_copying_any,
    output logic                          transmit_in_progress_any,
    output logic [cmbs_pkg::NBUF-1:0]     irq_pending
);
    localparam int N = cmbs_pkg::NBUF;

    cmbs_pkg::cmbs_buf_t    buf_q [N];
    logic                   buffer_lock_enable;
    logic [N-1:0]           ien;
    logic [N-1:0]           ipnd;
    logic                   cur_valid;
    logic [3:0]             cur_idx;
    logic                   sched_valid;
    logic [3:0]             sched_idx;
    logic                   retry_wait;
    logic                   copy_valid;
    logic [3:0]             copy_idx;

    // AHB address phase capture
    logic                   dp_write;
    logic [7:0]             dp_addr;

    wire        ap_take    = hsel && hready && htrans[1];
    wire        wr_now     = dp_write;
    wire        buf_region = dp_addr >= cmbs_pkg::ADDR_BUF0;
    wire [7:0]  buf_off    = dp_addr - cmbs_pkg::ADDR_BUF0;
    wire [3:0]  wr_buf     = buf_off[5:2];
    wire        wr_buf_ok  = wr_now && buf_region && (buf_off[7:6] == 2'b00) && (wr_buf < 4'(N));

    // Transmit requests: once or answer-once, idle, not current/scheduled
    logic [N-1:0]   tx_req;
    logic [4*N-1:0] pri_flat;
    logic           pick_found;
    logic [3:0]     pick_idx;
    logic [7:0]     pick_best;
    logic [7:0]     sched_pri;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            tx_req[i] = buf_q[i].st[3] && buf_q[i].st[2] && !buf_q[i].st[0];
            pri_flat[4*i +: 4] = buf_q[i].transmit_priority_value;
        end
    end

    cmbs_pick u_pick (
        .req      (tx_req),
        .pri_code (pri_flat),
        .found    (pick_found),
        .idx      (pick_idx),
        .best     (pick_best)
    );

    assign sched_pri = {buf_q[sched_idx].transmit_priority_value, sched_idx};

    // Write-time state after software: busy bit always kept by hardware
    logic [3:0] sw_st [N];
    logic [3:0] rx_nxt [N];

    generate
        for (genvar g = 0; g < N; g++) begin : g_rx
            always_comb begin
                sw_st[g] = buf_q[g].st;
                if (wr_buf_ok && wr_buf == 4'(g))
                    sw_st[g] = {hwdata[3:1], buf_q[g].st[0]};
            end
            cmbs_rxnext u_rxn (
                .cur (sw_st[g]),
                .nxt (rx_nxt[g])
            );
        end
    endgenerate

    // Lock: full/overrun buffers are skipped when lock is on
    wire [3:0] rx_b = evt.rx_buf;
    wire rx_target_ok = (rx_b < 4'(N)) && !buf_q[rx_b].st[3] && buf_q[rx_b].st != cmbs_pkg::ST_RX_NOT_ACTIVE
                        && !(buffer_lock_enable && buf_q[rx_b].st[2]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= ap_take && hwrite;
            dp_addr  <= ap_take ? haddr : dp_addr;
        end
    end

    // Main state update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N; i++) begin
                buf_q[i] <= '0;
            end
            buffer_lock_enable <= 1'b0;
            ien          <= '0;
            ipnd         <= '0;
            cur_valid    <= 1'b0;
            cur_idx      <= 4'h0;
            sched_valid  <= 1'b0;
            sched_idx    <= 4'h0;
            retry_wait   <= 1'b0;
            copy_valid   <= 1'b0;
            copy_idx     <= 4'h0;
        end else begin
            logic [N-1:0] set_p;
            logic [3:0]   nst [N];
            logic         ncur_v;
            logic         nsch_v;
            logic [3:0]   nsch_i;
            set_p  = '0;
            ncur_v = cur_valid;
            nsch_v = sched_valid;
            nsch_i = sched_idx;
            for (int i = 0; i < N; i++) begin
                nst[i] = sw_st[i];
            end

            // Other register writes; priority and flag protected while busy
            if (wr_buf_ok && !buf_q[wr_buf].st[0]) begin
                buf_q[wr_buf].transmit_priority_value <= hwdata[cmbs_pkg::FLD_PRI_LO +: 4];
                buf_q[wr_buf].rtr <= hwdata[cmbs_pkg::FLD_RTR];
            end
            if (wr_now && dp_addr == cmbs_pkg::ADDR_CFG)
                buffer_lock_enable <= hwdata[cmbs_pkg::CFG_LOCK];
            if (wr_now && dp_addr == cmbs_pkg::ADDR_IEN)
                ien <= hwdata[N-1:0];

            // Receive: busy during copy, then full/overrun
            if (evt.rx_valid && !copy_valid && rx_target_ok) begin
                nst[rx_b][0] = 1'b1;
                copy_valid <= 1'b1;
                copy_idx   <= rx_b;
            end
            if (copy_valid && evt.rx_copy_done) begin
                nst[copy_idx] = rx_nxt[copy_idx];
                nst[copy_idx][0] = 1'b0;
                copy_valid <= 1'b0;
                if (rx_nxt[copy_idx] != sw_st[copy_idx])
                    set_p[copy_idx] = 1'b1;
            end

            // Remote frame wakes waiting buffers
            if (evt.rx_remote && rx_b < 4'(N) && buf_q[rx_b].st == cmbs_pkg::ST_AWAIT_REMOTE_REQUEST) begin
                nst[rx_b] = cmbs_pkg::ST_REMOTE_ANSWER_ONCE;
                set_p[rx_b] = 1'b1;
            end

            // Transmission outcome of the current buffer
            if (cur_valid && evt.tx_ok) begin
                ncur_v = 1'b0;
                set_p[cur_idx] = 1'b1;
                if (sw_st[cur_idx][3:1] == cmbs_pkg::ST_REMOTE_ANSWER_ONCE[3:1])
                    nst[cur_idx] = cmbs_pkg::ST_AWAIT_REMOTE_REQUEST;
                else if (buf_q[cur_idx].rtr)
                    nst[cur_idx] = cmbs_pkg::ST_RX_READY;
                else
                    nst[cur_idx] = cmbs_pkg::ST_TX_NOT_ACTIVE;
            end else if (cur_valid && evt.tx_fail) begin
                retry_wait <= 1'b1;
            end
            if (retry_wait && evt.bus_idle)
                retry_wait <= 1'b0;

            // Scheduled buffer cancelled by software leaves the schedule
            if (sched_valid && !sw_st[sched_idx][2]) begin
                nst[sched_idx][0] = 1'b0;
                nsch_v = 1'b0;
            end

            // Scheduling window opens at CRC start or while no buffer is current and no retry wait
            if ((evt.crc_start || (!cur_valid && !retry_wait)) && pick_found) begin
                if (!nsch_v) begin
                    nsch_v = 1'b1;
                    nsch_i = pick_idx;
                    nst[pick_idx][0] = 1'b1;
                end else if (pick_best < sched_pri) begin
                    nst[sched_idx][0] = 1'b0;
                    nst[pick_idx][0] = 1'b1;
                    nsch_i = pick_idx;
                end
            end
            if (evt.frame_start && nsch_v && !(cur_valid && !retry_wait)) begin
                ncur_v = 1'b1;
                cur_idx <= nsch_i;
                nsch_v = 1'b0;
            end
            cur_valid   <= ncur_v;
            sched_valid <= nsch_v;
            sched_idx   <= nsch_i;

            for (int i = 0; i < N; i++) begin
                buf_q[i].st <= nst[i];
            end

            // Set wins over clear
            if (wr_now && dp_addr == cmbs_pkg::ADDR_ICLR)
                ipnd <= (ipnd & ~hwdata[N-1:0]) | (set_p & ien);
            else
                ipnd <= ipnd | (set_p & ien);
        end
    end

    // Read mux on the address phase so hrdata stands through the data phase;
    // a write whose data phase ends at that same edge is not yet visible
    logic [31:0] rd_word;
    wire  [3:0]  rd_buf = haddr[5:2];
    always_comb begin
        rd_word = cmbs_pkg::RESET_WORD;
        if (haddr == cmbs_pkg::ADDR_CFG)
            rd_word[0] = buffer_lock_enable;
        else if (haddr == cmbs_pkg::ADDR_STAT)
            rd_word[1:0] = {transmit_in_progress_any, receive_copying_any};
        else if (haddr == cmbs_pkg::ADDR_IPND)
            rd_word[N-1:0] = ipnd;
        else if (haddr == cmbs_pkg::ADDR_IEN)
            rd_word[N-1:0] = ien;
        else if (haddr >= cmbs_pkg::ADDR_BUF0 && haddr[7:6] == 2'b01 && rd_buf < 4'(N))
            rd_word[8:0] = buf_q[rd_buf];
    end

    // Outputs registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            tx_request               <= 1'b0;
            tx_buf                   <= 4'h0;
            tx_buf_rtr               <= 1'b0;
            receive_copying_any      <= 1'b0;
            transmit_in_progress_any <= 1'b0;
            irq_pending              <= '0;
        end else begin
            hrdata    <= (ap_take && !hwrite) ? rd_word : hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            // Drop on the outcome edge itself, not a cycle later
            tx_request               <= cur_valid && !retry_wait && !evt.tx_ok && !evt.tx_fail;
            tx_buf                   <= cur_idx;
            tx_buf_rtr               <= buf_q[cur_idx].rtr;
            receive_copying_any      <= copy_valid ? !evt.rx_copy_done
                                                   : (evt.rx_valid && rx_target_ok);
            transmit_in_progress_any <= cur_valid || sched_valid;
            irq_pending              <= ipnd;
        end
    end
endmodule
`default_nettype wire

// ---- tb/cmbs_ctrl_sva.sv ----
/*
 * Port checker for cmbs_ctrl: receive copy, transmit and pending-flag timing.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps
`default_nettype none
module cmbs_ctrl_sva (
    input wire logic                      hclk,
    input wire logic                      hresetn,
    input wire logic                      hsel,
    input wire logic [7:0]                haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic                      hready,
    input wire cmbs_pkg::cmbs_evt_t       evt,
    input wire logic                      tx_request,
    input wire logic [3:0]                tx_buf,
    input wire logic                      receive_copying_any,
    input wire logic                      transmit_in_progress_any,
    input wire logic [cmbs_pkg::NBUF-1:0] irq_pending
);
    logic wr_ie;
    wire  cause = evt.rx_copy_done || evt.tx_ok || evt.rx_remote || wr_ie;

    // Data phase of a clear or enable write; pending may only drop after one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_ie <= 1'b0;
        else wr_ie <= hsel && hready && htrans[1] && hwrite &&
                      (haddr == cmbs_pkg::ADDR_ICLR || haddr == cmbs_pkg::ADDR_IEN);
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_sent;
        tx_request && (evt.tx_ok || evt.tx_fail);
    endsequence

    property p_copy_end;  receive_copying_any && evt.rx_copy_done |=> !receive_copying_any; endproperty
    property p_copy_hold; receive_copying_any && !evt.rx_copy_done |=> receive_copying_any; endproperty
    property p_copy_src;  $rose(receive_copying_any) |-> $past(evt.rx_valid); endproperty
    property p_tx_go;     $rose(tx_request) |-> $past(evt.frame_start || evt.bus_idle, 2); endproperty
    property p_tx_end;    s_sent |=> !tx_request; endproperty
    property p_tx_busy;   tx_request |-> transmit_in_progress_any; endproperty
    property p_tx_hold;
        tx_request && !evt.tx_ok && !evt.tx_fail |=> tx_request && $stable(tx_buf);
    endproperty
    property p_pend_fall;
        (|($past(irq_pending) & ~irq_pending)) |-> ($past(wr_ie) || $past(wr_ie, 2));
    endproperty
    property p_pend_rise;
        (|(irq_pending & ~$past(irq_pending))) |-> ($past(cause) || $past(cause, 2));
    endproperty

    a_copy_end:  assert property (p_copy_end) else $error("copy flag stuck after copy done");
    a_copy_hold: assert property (p_copy_hold) else $error("copy flag dropped early");
    a_copy_src:  assert property (p_copy_src) else $error("copy flag without frame");
    a_tx_go:     assert property (p_tx_go) else $error("send began without start");
    a_tx_end:    assert property (p_tx_end) else $error("send did not stop");
    a_tx_busy:   assert property (p_tx_busy) else $error("send without busy flag");
    a_tx_hold:   assert property (p_tx_hold) else $error("send dropped or buffer moved");
    a_pend_fall: assert property (p_pend_fall) else $error("pending dropped by itself");
    a_pend_rise: assert property (p_pend_rise) else $error("pending rose without cause");
endmodule

bind cmbs_ctrl cmbs_ctrl_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .evt(evt), .tx_request(tx_request),
    .tx_buf(tx_buf), .receive_copying_any(receive_copying_any),
    .transmit_in_progress_any(transmit_in_progress_any), .irq_pending(irq_pending));
`default_nettype wire

// ---- tb/cmbs_node_model.sv ----
/*
 * Far side: other bus nodes, seen as the protocol engine's one-cycle pulses.
 * Assumes callers run on hclk; every task starts at a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module cmbs_node_model (
    input  wire logic           hclk,
    output cmbs_pkg::cmbs_evt_t evt
);
    logic [3:0] last_buf;

    initial begin
        evt = '0;
        last_buf = 4'h0;
    end

    // Idle buffer lines show the inverse of the last number, never a stale copy
    task automatic send(input cmbs_pkg::cmbs_evt_t e);
        @(posedge hclk);
        evt <= e;
        last_buf = e.rx_buf;
        @(posedge hclk);
        evt <= '{rx_buf: ~last_buf, default: 1'b0};
        @(posedge hclk);
    endtask

    task automatic accept(input logic [3:0] b);
        send('{rx_valid: 1'b1, rx_buf: b, default: 1'b0});
    endtask

    task automatic copied(input logic [3:0] b);
        send('{rx_copy_done: 1'b1, rx_buf: b, default: 1'b0});
    endtask

    task automatic remote(input logic [3:0] b);
        send('{rx_remote: 1'b1, rx_buf: b, default: 1'b0});
    endtask

    // Slow or prompt copy, as the gap says
    task automatic frame(input logic [3:0] b, input int gap);
        accept(b);
        repeat (gap) @(posedge hclk);
        copied(b);
    endtask

    task automatic strobe(input logic fs, input logic ok, input logic fail, input logic idle);
        send('{frame_start: fs, tx_ok: ok, tx_fail: fail, bus_idle: idle, default: 1'b0});
    endtask
endmodule
`default_nettype wire

// ---- tb/cmbs_ctrl_test.sv ----
/*
 * Self-checking bench for cmbs_ctrl with a per-buffer state model.
 * Assumes read data stands in the data phase; every bus wait is bounded.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module cmbs_ctrl_test;
    logic                      hclk;
    logic                      hresetn;
    logic                      hsel;
    logic [7:0]                haddr;
    logic [1:0]                htrans;
    logic                      hwrite;
    logic [31:0]               hwdata;
    logic [31:0]               hrdata;
    logic                      hreadyout;
    logic                      hresp;
    cmbs_pkg::cmbs_evt_t       evt;
    logic                      tx_request;
    logic [3:0]                tx_buf;
    logic                      tx_buf_rtr;
    logic                      rx_any;
    logic                      tx_any;
    logic [cmbs_pkg::NBUF-1:0] irq_pending;
    logic [31:0]               rd_word;
    int                        num_errors;
    int                        cmp_count;
    int                        seed;
    int                        b;
    int                        model_st [cmbs_pkg::NBUF];

    cmbs_ctrl i_cmbs_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .evt(evt), .tx_request(tx_request), .tx_buf(tx_buf), .tx_buf_rtr(tx_buf_rtr),
        .receive_copying_any(rx_any), .transmit_in_progress_any(tx_any),
        .irq_pending(irq_pending));
    cmbs_node_model node (.hclk(hclk), .evt(evt));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            test_done();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd_word = hrdata;
    endtask

    function automatic logic [31:0] bw(input logic r, input logic [3:0] p, input logic [3:0] s);
        return {23'h0, r, p, s};
    endfunction

    task automatic wr(input int n, input logic [31:0] d);
        bus(1'b1, cmbs_pkg::ADDR_BUF0 + 8'(4 * n), d);
    endtask

    task automatic cb(input int n);
        bus(1'b0, cmbs_pkg::ADDR_BUF0 + 8'(4 * n), 32'h0);
        `CHK("state", 4'(model_st[n]), rd_word[3:0])
        `CHK("okay", 1'b0, hresp)
    endtask

    task automatic mid();
        @(posedge hclk);
        @(negedge hclk);
    endtask

    initial begin
        seed = 32'h9a29;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        num_errors = 0;
        cmp_count = 0;
        foreach (model_st[i]) model_st[i] = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < cmbs_pkg::NBUF; i++) cb(i);
        bus(1'b1, 8'h30, 32'hffff_ffff);
        bus(1'b0, 8'h30, 32'h0);
        `CHK("unmapped", 32'h0, rd_word)
        $display("end of reset test");
        b = $unsigned($random(seed)) % 14;
        bus(1'b1, cmbs_pkg::ADDR_IEN, 32'h1 << b);
        wr(b, 32'(cmbs_pkg::ST_RX_READY));
        model_st[b] = cmbs_pkg::ST_RX_READY;
        cb(b);
        for (int k = 0; k < 2; k++) begin
            node.accept(4'(b));
            model_st[b] = model_st[b] | 1;
            mid();
            `CHK("copying", 1'b1, rx_any)
            cb(b);
            node.copied(4'(b));
            model_st[b] = (k == 0) ? cmbs_pkg::ST_RX_FULL : cmbs_pkg::ST_RX_OVERRUN;
            cb(b);
            `CHK("pending", 1'b1, irq_pending[b])
        end
        node.accept(4'(b));
        wr(b, 32'(cmbs_pkg::ST_RX_READY));
        model_st[b] = cmbs_pkg::ST_RX_READY | 1;
        cb(b);
        node.copied(4'(b));
        model_st[b] = cmbs_pkg::ST_RX_FULL;
        cb(b);
        bus(1'b1, cmbs_pkg::ADDR_ICLR, 32'h1 << b);
        mid();
        `CHK("pending", 15'h0, irq_pending)
        bus(1'b1, cmbs_pkg::ADDR_CFG, 32'h1);
        wr(11, 32'(cmbs_pkg::ST_RX_READY));
        for (int k = 0; k < 2; k++) node.frame(4'd11, $unsigned($random(seed)) % 8);
        model_st[11] = cmbs_pkg::ST_RX_FULL;
        cb(11);
        wr(11, 32'(cmbs_pkg::ST_RX_READY));
        model_st[11] = cmbs_pkg::ST_RX_READY;
        cb(11);
        bus(1'b1, cmbs_pkg::ADDR_CFG, 32'h0);
        $display("end of receive test");
        wr(2, bw(1'b0, 4'h3, cmbs_pkg::ST_TX_ONCE));
        model_st[2] = cmbs_pkg::ST_TX_ONCE | 1;
        cb(2);
        wr(2, bw(1'b0, 4'hf, cmbs_pkg::ST_TX_ONCE));
        cb(2);
        `CHK("priority", 4'h3, rd_word[7:4])
        node.strobe(1'b1, 1'b0, 1'b0, 1'b0);
        mid();
        `CHK("sending", 5'h12, {tx_request, tx_buf})
        node.strobe(1'b0, 1'b0, 1'b1, 1'b0);
        mid();
        `CHK("stopped", 1'b0, tx_request)
        cb(2);
        node.strobe(1'b0, 1'b0, 1'b0, 1'b1);
        mid();
        `CHK("retry", 5'h12, {tx_request, tx_buf})
        node.strobe(1'b0, 1'b1, 1'b0, 1'b0);
        model_st[2] = cmbs_pkg::ST_TX_NOT_ACTIVE;
        cb(2);
        wr(7, bw(1'b0, 4'h1, cmbs_pkg::ST_TX_ONCE));
        model_st[7] = cmbs_pkg::ST_TX_ONCE | 1;
        cb(7);
        wr(9, bw(1'b0, 4'h0, cmbs_pkg::ST_TX_ONCE));
        model_st[7] = cmbs_pkg::ST_TX_ONCE;
        model_st[9] = cmbs_pkg::ST_TX_ONCE | 1;
        cb(7);
        cb(9);
        node.strobe(1'b1, 1'b0, 1'b0, 1'b0);
        mid();
        `CHK("sending", 5'h19, {tx_request, tx_buf})
        node.strobe(1'b0, 1'b1, 1'b0, 1'b0);
        model_st[9] = cmbs_pkg::ST_TX_NOT_ACTIVE;
        model_st[7] = cmbs_pkg::ST_TX_ONCE | 1;
        cb(9);
        cb(7);
        wr(7, bw(1'b0, 4'h1, cmbs_pkg::ST_TX_NOT_ACTIVE));
        model_st[7] = cmbs_pkg::ST_TX_NOT_ACTIVE;
        cb(7);
        $display("end of transmit test");
        wr(3, bw(1'b1, 4'h0, cmbs_pkg::ST_TX_ONCE));
        node.strobe(1'b1, 1'b0, 1'b0, 1'b0);
        mid();
        `CHK("remote", 1'b1, tx_buf_rtr)
        node.strobe(1'b0, 1'b1, 1'b0, 1'b0);
        model_st[3] = cmbs_pkg::ST_RX_READY;
        cb(3);
        node.frame(4'd3, 2);
        model_st[3] = cmbs_pkg::ST_RX_FULL;
        cb(3);
        wr(6, bw(1'b0, 4'h0, cmbs_pkg::ST_REMOTE_ANSWER_ONCE));
        model_st[6] = cmbs_pkg::ST_REMOTE_ANSWER_ONCE | 1;
        cb(6);
        for (int k = 0; k < 2; k++) begin
            node.strobe(1'b1, 1'b0, 1'b0, 1'b0);
            node.strobe(1'b0, 1'b1, 1'b0, 1'b0);
            model_st[6] = cmbs_pkg::ST_AWAIT_REMOTE_REQUEST;
            cb(6);
            node.remote(4'd6);
            model_st[6] = cmbs_pkg::ST_REMOTE_ANSWER_ONCE | 1;
            cb(6);
        end
        $display("end of remote test");
        test_done();
    end
endmodule
`default_nettype wire
